//--- common/sts_timing_regs.vh
// register map, reset values and timing counts of the sensor timing block
`ifndef STS_TIMING_REGS_VH
`define STS_TIMING_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADDR_WIN_HEIGHT 8'h03
`define ADDR_WIN_WIDTH 8'h04
`define ADDR_HBLANK 8'h05
`define ADDR_VBLANK 8'h06
`define ADDR_CHIP_CTRL 8'h07
`define ADDR_SHUTTER 8'h0B
`define ADDR_READ_MODE 8'h0D
`define ADDR_AV_CTRL 8'hC3
`define ADDR_AV_HBLANK 8'hC4
`define ADDR_AV_VBLANK 8'hC5
`define ADDR_BYTE_PORT 8'hF0
`define ADDR_WR_PROTECT 8'hFE

// ----------------------------------------------------------------------
// field positions and encodings
// ----------------------------------------------------------------------
`define CTRL_MODE_HI 4
`define CTRL_MODE_LO 3
`define CTRL_SIMUL_BIT 8
`define AV_REPLACE_BIT 1
`define MODE_MASTER 2'h0
`define MODE_SNAPSHOT 2'h1
`define MODE_SLAVE 2'h3
`define LOCK_ALL_CODE 16'hDEAD
`define LOCK_ONE_CODE 16'hDEAF
`define UNLOCK_CODE 16'hBEEF

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_WIN_HEIGHT 16'h01E0
`define RST_WIN_WIDTH 16'h02F0
`define RST_HBLANK 16'h005E
`define RST_VBLANK 16'h002D
`define RST_CHIP_CTRL 16'h0100
`define RST_SHUTTER 16'h01E0
`define RST_READ_MODE 16'h0300
`define RST_AV_CTRL 16'h0000
`define RST_AV_HBLANK 16'h4416
`define RST_AV_VBLANK 16'h4421
`define RST_WR_PROTECT 16'hBEEF

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define MIN_VBLANK_ROWS 16'h0004
`define SLAVE_LV_DELAY 16'h0004
`define EQ_ROWS_END 16'h0003
`define SERR_ROWS_END 16'h0006

`endif

//--- logic/sts_sync3.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module sts_sync3 #(
  parameter W = 3
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // asynchronous pins and filtered levels
  input wire [W-1:0] i_pin,
  output reg [W-1:0] o_level
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  // s1 only feeds s2; a bit changes once s2 and s3 agree on it
  always @(posedge i_clk) begin
    if (i_rst) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      o_level <= {W{1'b0}};
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      o_level <= (o_level & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
    end
  end

endmodule // sts_sync3

//--- logic/sts_timing_top.v
// sensor timing core: registers, operating modes, valid and sync outputs
`timescale 1ns/1ps
`include "sts_timing_regs.vh"

// Functional notes
// - replace bit set: frame/line valid pins carry pedestal and sync
// - front porch lasts low byte of horizontal register, master clocks
// - sync pulse lasts high byte of horizontal register, master clocks
// - equalizing pulse lasts low byte of vertical register
// - serration pulse lasts high byte of vertical register
// - byte port address gives 8-bit reads and writes of registers
// - code DEAD locks all but lock register; BEEF unlocks
// - while globally locked, writes to other registers are ignored
// - code DEAF protects only register 13 until unlocked
// - three modes: master, snapshot, slave; one at a time
// - master mode makes all readout timing internally
// - snapshot: external trigger starts exposure, then own readout
// - slave: external pulses steer exposure and each row readout
// - shutter register sets exposure except in slave mode
// - simultaneous master exposes during previous frame readout
// - long exposure stretches vertical blanking to fit it
// - sequential master exposes first, then reads out
// - vertical blanking never shorter than four rows
module sts_timing_top (
  // clock and reset
  input wire I_MCLK,
  input wire I_SRST,
  // serial register access
  input wire I_REG_WR,
  input wire I_REG_RD,
  input wire [7:0] I_REG_ADDR,
  input wire [15:0] I_REG_WDATA,
  output reg [15:0] O_REG_RDATA,
  output reg O_REG_RVALID,
  // external control pins
  input wire I_EXPOSURE,
  input wire I_FRAME_START,
  input wire I_LINE_START,
  // video timing outputs
  output reg O_FRAME_VALID,
  output reg O_LINE_VALID,
  output reg O_EXPOSING
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam ST_WAIT = 2'h0, ST_EXPOSE = 2'h1;
  localparam ST_READ = 2'h2, ST_BLANK = 2'h3;
  reg [15:0] win_height, win_width, hblank, vblank, chip_ctrl;
  reg [15:0] shutter, read_mode, av_ctrl, av_hblank, av_vblank;
  wire [15:0] protect_code;
  wire wr_accept;
  reg [7:0] last_addr, byte_hold, eff_addr;
  reg byte_pend, rd_phase, eff_wr;
  reg [15:0] eff_data;
  wire [2:0] pins;
  reg [2:0] pins_d;
  wire exp_rise, frm_rise, line_rise;
  reg [1:0] state;
  reg [15:0] hcnt, row;
  reg row_run;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function [15:0] max16;
    input [15:0] a;
    input [15:0] b;
    begin
      max16 = (a > b) ? a : b;
    end
  endfunction

  // register read decode, shared by word and byte reads
  function [15:0] read_reg;
    input [7:0] a;
    begin
      case (a)
        `ADDR_WIN_HEIGHT: read_reg = win_height;
        `ADDR_WIN_WIDTH: read_reg = win_width;
        `ADDR_HBLANK: read_reg = hblank;
        `ADDR_VBLANK: read_reg = vblank;
        `ADDR_CHIP_CTRL: read_reg = chip_ctrl;
        `ADDR_SHUTTER: read_reg = shutter;
        `ADDR_READ_MODE: read_reg = read_mode;
        `ADDR_AV_CTRL: read_reg = av_ctrl;
        `ADDR_AV_HBLANK: read_reg = av_hblank;
        `ADDR_AV_VBLANK: read_reg = av_vblank;
        `ADDR_WR_PROTECT: read_reg = protect_code;
        default: read_reg = 16'h0000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // byte-wide access port
  // ----------------------------------------------------------------------
  // a byte pair at the port becomes one word write to the last address
  always @* begin
    eff_wr = 1'b0;
    eff_addr = I_REG_ADDR;
    eff_data = I_REG_WDATA;
    if (I_REG_WR) begin
      if (I_REG_ADDR == `ADDR_BYTE_PORT) begin
        if (byte_pend) begin
          eff_wr = 1'b1;
          eff_addr = last_addr;
          eff_data = {byte_hold, I_REG_WDATA[7:0]};
        end
      end else begin
        eff_wr = 1'b1;
      end
    end
  end

  // lock filter sees the write after byte assembly
  sts_wr_protect u_protect (
    .i_clk (I_MCLK),
    .i_rst (I_SRST),
    .i_wr (eff_wr),
    .i_addr (eff_addr),
    .i_data (eff_data),
    .o_accept (wr_accept),
    .o_code (protect_code)
  );

  // byte pairing and the read answer, decoded at the edge from the live
  // registers; byte reads give the high byte first, then the low byte
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      last_addr <= 8'h00;
      byte_hold <= 8'h00;
      byte_pend <= 1'b0;
      rd_phase <= 1'b0;
      O_REG_RDATA <= 16'h0000;
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD && I_REG_ADDR == `ADDR_BYTE_PORT) begin
        O_REG_RDATA <= (read_reg(last_addr) >> {~rd_phase, 3'h0}) &
          16'h00FF;
      end else if (I_REG_RD) begin
        O_REG_RDATA <= read_reg(I_REG_ADDR);
      end
      if (I_REG_ADDR == `ADDR_BYTE_PORT) begin
        if (I_REG_WR) begin
          byte_pend <= ~byte_pend;
          byte_hold <= I_REG_WDATA[7:0];
        end
        if (I_REG_RD) begin
          rd_phase <= ~rd_phase;
        end
      end else if (I_REG_WR || I_REG_RD) begin
        // a word access retargets the port and restarts its pairing
        last_addr <= I_REG_ADDR;
        byte_pend <= 1'b0;
        rd_phase <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      win_height <= `RST_WIN_HEIGHT;
      win_width <= `RST_WIN_WIDTH;
      hblank <= `RST_HBLANK;
      vblank <= `RST_VBLANK;
      chip_ctrl <= `RST_CHIP_CTRL;
      shutter <= `RST_SHUTTER;
      read_mode <= `RST_READ_MODE;
      av_ctrl <= `RST_AV_CTRL;
      av_hblank <= `RST_AV_HBLANK;
      av_vblank <= `RST_AV_VBLANK;
    end else if (wr_accept) begin
      case (eff_addr)
        `ADDR_WIN_HEIGHT: win_height <= eff_data;
        `ADDR_WIN_WIDTH: win_width <= eff_data;
        `ADDR_HBLANK: hblank <= eff_data;
        `ADDR_VBLANK: vblank <= eff_data;
        `ADDR_CHIP_CTRL: chip_ctrl <= eff_data;
        `ADDR_SHUTTER: shutter <= eff_data;
        `ADDR_READ_MODE: read_mode <= eff_data;
        `ADDR_AV_CTRL: av_ctrl <= eff_data;
        `ADDR_AV_HBLANK: av_hblank <= eff_data;
        `ADDR_AV_VBLANK: av_vblank <= eff_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // mode decode and derived counts
  // ----------------------------------------------------------------------
  // code 2 is not a mode; it runs as master so exactly three exist
  wire [1:0] mode = chip_ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire is_slave = (mode == `MODE_SLAVE);
  wire is_snap = (mode == `MODE_SNAPSHOT);
  wire is_master = ~is_slave & ~is_snap;
  wire simul = chip_ctrl[`CTRL_SIMUL_BIT];
  wire replace = av_ctrl[`AV_REPLACE_BIT];

  wire [15:0] vb_min = max16(vblank, `MIN_VBLANK_ROWS);
  wire [15:0] vb_need = max16(vb_min, shutter - win_height);
  // stretch only when the exposure overruns blank plus window
  wire [15:0] blank_rows = (is_master && simul &&
    shutter > win_height + vb_min) ? vb_need : vb_min;

  // slave rows wait hblank plus a fixed delay after their strobe
  wire [15:0] lv_start = is_slave ? hblank + `SLAVE_LV_DELAY : hblank;
  wire [15:0] row_last = lv_start + win_width - 16'h0001;
  wire row_end = row_run && (hcnt >= row_last); // shrunk rows end at once
  wire [15:0] row_limit = (state == ST_EXPOSE) ? shutter :
    (state == ST_READ) ? win_height : blank_rows;
  wire limit_hit = (row + 16'h0001 >= row_limit);

  // ----------------------------------------------------------------------
  // external pins
  // ----------------------------------------------------------------------
  sts_sync3 #(
    .W (3)
  ) u_sync (
    .i_clk (I_MCLK),
    .i_rst (I_SRST),
    .i_pin ({I_LINE_START, I_FRAME_START, I_EXPOSURE}),
    .o_level (pins)
  );

  // edge detect on filtered levels; the delayed copy is kept by the sequencer
  assign exp_rise = pins[0] & ~pins_d[0];
  assign frm_rise = pins[1] & ~pins_d[1];
  assign line_rise = pins[2] & ~pins_d[2];

  // ----------------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------------
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      state <= ST_WAIT;
      hcnt <= 16'h0000;
      row <= 16'h0000;
      row_run <= 1'b0;
      pins_d <= 3'h0;
    end else begin
      pins_d <= pins;
      case (state)
        ST_WAIT: begin
          hcnt <= 16'h0000;
          row <= 16'h0000;
          if (is_master) begin
            row_run <= 1'b1;
            state <= simul ? ST_READ : ST_EXPOSE;
          end else if (exp_rise) begin
            row_run <= is_snap;
            state <= ST_EXPOSE;
          end
        end
        default: begin
          if (is_slave && state == ST_EXPOSE) begin
            // the frame strobe ends exposure and opens readout
            if (frm_rise) begin
              state <= ST_READ;
              row <= 16'h0000;
              row_run <= 1'b0;
            end
          end else if (is_slave && !row_run) begin
            // each line strobe reads one row, blanking rows included
            if (line_rise) begin
              row_run <= 1'b1;
              hcnt <= 16'h0000;
            end
          end else if (row_end) begin
            hcnt <= 16'h0000;
            row_run <= ~is_slave;
            if (limit_hit) begin
              row <= 16'h0000;
              if (state == ST_EXPOSE) begin
                state <= ST_READ;
              end else if (state == ST_READ) begin
                state <= ST_BLANK;
              end else if (is_master) begin
                state <= simul ? ST_READ : ST_EXPOSE;
              end else begin
                state <= ST_WAIT;
              end
            end else begin
              row <= row + 16'h0001;
            end
          end else if (row_run) begin
            hcnt <= hcnt + 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // valid, exposure and analog-style sync outputs
  // ----------------------------------------------------------------------
  // rows left in the frame decide the overlapped exposure window
  wire [15:0] rows_left = (state == ST_READ) ?
    win_height - row + blank_rows :
    (state == ST_BLANK) ? blank_rows - row : 16'h0000;
  wire fv_raw = (state == ST_READ);
  wire lv_raw = fv_raw && row_run && (hcnt >= lv_start);
  wire exp_raw = (is_master && simul) ?
    (shutter != 16'h0000 && rows_left <= shutter) :
    (state == ST_EXPOSE);

  // blanking rows use equalizing then serration widths, then sync
  wire [15:0] front_porch = {8'h00, av_hblank[7:0]};
  wire [15:0] pulse_w = (state != ST_READ && row < `EQ_ROWS_END) ?
    {8'h00, av_vblank[7:0]} :
    (state != ST_READ && row < `SERR_ROWS_END) ?
    {8'h00, av_vblank[15:8]} :
    {8'h00, av_hblank[15:8]};
  wire sync_raw = row_run && (hcnt >= front_porch) &&
    (hcnt < front_porch + pulse_w);
  // pedestal marks the blanking level between active pixels
  wire ped_raw = ~lv_raw;

  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_FRAME_VALID <= 1'b0;
      O_LINE_VALID <= 1'b0;
      O_EXPOSING <= 1'b0;
    end else begin
      O_FRAME_VALID <= replace ? ped_raw : fv_raw;
      O_LINE_VALID <= replace ? sync_raw : lv_raw;
      O_EXPOSING <= exp_raw;
    end
  end

endmodule // sts_timing_top

//--- logic/sts_wr_protect.v
// write-protection code register and write filter
`timescale 1ns/1ps
`include "sts_timing_regs.vh"

module sts_wr_protect (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // candidate write
  input wire i_wr,
  input wire [7:0] i_addr,
  input wire [15:0] i_data,
  // filter result and stored code
  output wire o_accept,
  output reg [15:0] o_code
);

  wire lock_all;
  wire lock_one;
  wire is_code_reg;

  // decode of the stored code
  assign lock_all = (o_code == `LOCK_ALL_CODE);
  assign lock_one = (o_code == `LOCK_ONE_CODE);
  assign is_code_reg = (i_addr == `ADDR_WR_PROTECT);

  // the code register itself stays writable so a lock can be undone
  assign o_accept = i_wr & (is_code_reg |
    (~lock_all & ~(lock_one & (i_addr == `ADDR_READ_MODE))));

  // any value is stored; only the two lock codes DEAD and DEAF have an effect
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_code <= `RST_WR_PROTECT;
    end else if (i_wr && is_code_reg) begin
      o_code <= i_data;
    end
  end

endmodule // sts_wr_protect

//--- verif/sts_capture_host.sv
// capture host model: drives trigger, frame and row pins
`timescale 1ns/1ps
module sts_capture_host (
  // clock and command
  input wire i_clk,
  input wire i_go,
  input wire i_slave,
  // control pins toward the sensor
  output reg o_exposure,
  output reg o_frame_start,
  output reg o_line_start
);
  // pins rest low until the first capture
  initial begin
    o_exposure = 1'b0;
    o_frame_start = 1'b0;
    o_line_start = 1'b0;
  end

  // pulses last 8 clocks so the 4-edge pin filter cannot miss them
  always begin
    @(posedge i_go);
    @(negedge i_clk);
    o_exposure = 1'b1;
    repeat (8) @(negedge i_clk);
    o_exposure = 1'b0;
    if (i_slave) begin
      repeat (100) @(negedge i_clk);
      o_frame_start = 1'b1;
      repeat (8) @(negedge i_clk);
      o_frame_start = 1'b0;
      // 8 active and 4 blank rows, spaced past one full row readout
      repeat (12) begin
        repeat (40) @(negedge i_clk);
        o_line_start = 1'b1;
        repeat (8) @(negedge i_clk);
        o_line_start = 1'b0;
        repeat (72) @(negedge i_clk);
      end
    end
  end
endmodule // sts_capture_host

//--- verif/sts_timing_top_monitor.sv
// port-level checker for the sensor timing block
`timescale 1ns/1ps
module sts_timing_monitor (
  // clock and reset
  input wire I_MCLK,
  input wire I_SRST,
  // register access
  input wire I_REG_WR,
  input wire I_REG_RD,
  input wire [7:0] I_REG_ADDR,
  input wire [15:0] I_REG_WDATA,
  input wire [15:0] O_REG_RDATA,
  input wire O_REG_RVALID,
  // pins and video outputs
  input wire I_EXPOSURE,
  input wire I_FRAME_START,
  input wire I_LINE_START,
  input wire O_FRAME_VALID,
  input wire O_LINE_VALID,
  input wire O_EXPOSING
);
  logic [15:0] lock_code;
  logic [15:0] sh_hb;
  logic [15:0] sh_r13;
  logic repl;
  logic repl_d1;
  logic repl_d2;
  wire wr_ok = I_REG_WR && (lock_code != 16'hDEAD || I_REG_ADDR == 8'hFE);

  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);

  // shadows of the word writes that the lock lets through
  // byte-port writes are not tracked, so benches keep them off these
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      lock_code <= 16'hBEEF;
      sh_hb <= 16'h4416;
      sh_r13 <= 16'h0300;
      repl <= 1'b0;
    end else begin
      if (I_REG_WR && I_REG_ADDR == 8'hFE) lock_code <= I_REG_WDATA;
      if (wr_ok && I_REG_ADDR == 8'hC4) sh_hb <= I_REG_WDATA;
      if (wr_ok && I_REG_ADDR == 8'h0D && lock_code != 16'hDEAF)
        sh_r13 <= I_REG_WDATA;
      if (wr_ok && I_REG_ADDR == 8'hC3) repl <= I_REG_WDATA[1];
    end
    repl_d1 <= repl;
    repl_d2 <= repl_d1;
  end

  read_answer_a: assert property (I_REG_RD |=> O_REG_RVALID)
    else $error("read request got no answer strobe");
  answer_cause_a: assert property (O_REG_RVALID |-> $past(I_REG_RD))
    else $error("answer strobe without a read request");
  rdata_hold_a: assert property (!O_REG_RVALID |-> $stable(O_REG_RDATA))
    else $error("read data moved without a read");
  lock_readback_a: assert property ((I_REG_WR && I_REG_ADDR == 8'hFE)
    ##2 (I_REG_RD && I_REG_ADDR == 8'hFE)
    |=> O_REG_RDATA == $past(I_REG_WDATA, 3)) else $error("lock code lost");
  hblank_shadow_a: assert property ((I_REG_RD && I_REG_ADDR == 8'hC4)
    |=> O_REG_RDATA == $past(sh_hb)) else $error("blanking word wrong");
  reg13_shadow_a: assert property ((I_REG_RD && I_REG_ADDR == 8'h0D)
    |=> O_REG_RDATA == $past(sh_r13)) else $error("register 13 wrong");
  unmapped_zero_a: assert property ((I_REG_RD && I_REG_ADDR == 8'hE0)
    |=> O_REG_RDATA == 16'h0000) else $error("unmapped read not zero");
  line_in_frame_a: assert property ((!repl && !repl_d1 && !repl_d2
    && O_LINE_VALID) |-> O_FRAME_VALID) else $error("line outside frame");
endmodule // sts_timing_monitor

bind sts_timing_top sts_timing_monitor u_mon (.I_MCLK(I_MCLK),
  .I_SRST(I_SRST), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
  .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID),
  .I_EXPOSURE(I_EXPOSURE), .I_FRAME_START(I_FRAME_START),
  .I_LINE_START(I_LINE_START), .O_FRAME_VALID(O_FRAME_VALID),
  .O_LINE_VALID(O_LINE_VALID), .O_EXPOSING(O_EXPOSING));

//--- verif/sts_timing_top_tb_top.sv
// self-checking bench for the sensor timing block
`timescale 1ns/1ps
module sts_timing_top_tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  wire exposure;
  wire frame_start;
  wire line_start;
  logic fv;
  logic lv;
  logic expo;
  logic go = 1'b0;
  logic slave = 1'b0;
  logic [15:0] rdv, lines, lvw, fvl, ovl, f2, w;
  logic [3:0] seen;
  logic [7:0] ra [5] = '{8'hC4, 8'hC5, 8'hFE, 8'h07, 8'hC3};
  logic [15:0] rv [5] = '{16'h4416, 16'h4421, 16'hBEEF, 16'h0100, 16'h0000};
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;

  // 100 MHz master clock
  always #5 mclk = ~mclk;

  sts_timing_top DUT (.I_MCLK(mclk), .I_SRST(srst), .I_REG_WR(reg_wr),
    .I_REG_RD(reg_rd), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
    .O_REG_RDATA(reg_rdata), .O_REG_RVALID(reg_rvalid),
    .I_EXPOSURE(exposure), .I_FRAME_START(frame_start),
    .I_LINE_START(line_start), .O_FRAME_VALID(fv), .O_LINE_VALID(lv),
    .O_EXPOSING(expo));
  sts_capture_host u_host (.i_clk(mclk), .i_go(go), .i_slave(slave),
    .o_exposure(exposure), .o_frame_start(frame_start),
    .o_line_start(line_start));

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and ends the run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      report_and_stop;
    end
  end

  task chk(input string name, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  // bus tasks start at a falling edge and end after one idle edge, so
  // a following call never lowers and raises a strobe in one step
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask

  task rd(input logic [7:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    rdv = reg_rdata;
    chk("read strobe", 16'h0001, {15'h0000, reg_rvalid});
    @(negedge mclk);
  endtask

  task rc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk("read data", e, rdv);
  endtask

  // small window keeps a frame near 1000 clocks
  task cfg(input logic [15:0] ctrl, input logic [15:0] shut);
    wr(8'h03, 16'h0008);
    wr(8'h04, 16'h0020);
    wr(8'h05, 16'h0030);
    wr(8'h06, 16'h0000);
    wr(8'h0B, shut);
    wr(8'h07, ctrl);
  endtask

  // measures the last of nf frames; the first may be cut by setup
  task meas(input int nf);
    logic p;
    int n;
    repeat (nf) begin
      lines = 16'h0000;
      lvw = 16'h0000;
      fvl = 16'h0000;
      ovl = 16'h0000;
      p = 1'b0;
      n = 0;
      while (fv !== 1'b1 && n < 6000) begin
        @(negedge mclk);
        n++;
      end
      while (fv === 1'b1 && n < 12000) begin
        if (lv === 1'b1 && !p) lines++;
        if (lv === 1'b1) lvw++;
        if (expo === 1'b1) ovl++;
        p = (lv === 1'b1);
        @(negedge mclk);
        n++;
      end
      while (fv !== 1'b1 && fvl < 16'h0BB8) begin
        @(negedge mclk);
        fvl++;
      end
    end
  endtask

  // main sequence
  initial begin
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    for (int i = 0; i < 5; i++) rc(ra[i], rv[i]);
    wr(8'hC5, 16'h0C07);
    rc(8'hC5, 16'h0C07);
    wr(8'hE0, 16'hFFFF);
    rc(8'hE0, 16'h0000);
    // global lock, then single-register lock
    wr(8'hFE, 16'hDEAD);
    wr(8'hC4, 16'h1234);
    rc(8'hC4, 16'h4416);
    wr(8'hFE, 16'hBEEF);
    rc(8'hFE, 16'hBEEF);
    wr(8'hFE, 16'hDEAF);
    wr(8'h0D, 16'h0001);
    rc(8'h0D, 16'h0300);
    wr(8'hC4, 16'h0A05);
    rc(8'hC4, 16'h0A05);
    wr(8'hFE, 16'hBEEF);
    wr(8'h0D, 16'h0001);
    rc(8'h0D, 16'h0001);
    wr(8'h0D, 16'h0300);
    // byte port: high byte then low byte to the last word address
    wr(8'h05, 16'h0030);
    wr(8'hF0, 16'h0000);
    wr(8'hF0, 16'h0040);
    rc(8'h05, 16'h0040);
    rd(8'hF0);
    chk("byte high", 16'h0000, {8'h00, rdv[7:0]});
    rd(8'hF0);
    chk("byte low", 16'h0040, {8'h00, rdv[7:0]});
    // master simultaneous: short exposure, then stretched blanking
    cfg(16'h0100, 16'h0004);
    meas(2);
    chk("line count", 16'h0008, lines);
    chk("line high clocks", 16'h0100, lvw);
    chk("blank clocks", 16'h0140, fvl);
    cfg(16'h0100, 16'h0014);
    meas(2);
    chk("stretched blank", 16'h03C0, fvl);
    chk("exposing in readout", 16'h0001, {15'h0000, ovl != 0});
    // master sequential: exposure precedes readout
    cfg(16'h0000, 16'h0004);
    meas(2);
    f2 = fvl;
    chk("exposing in readout", 16'h0000, ovl);
    cfg(16'h0000, 16'h0014);
    meas(2);
    chk("gap grows", 16'h0001, {15'h0000, fvl > f2});
    // replace mode: sync pulse widths on the line pin
    cfg(16'h0100, 16'h0004);
    wr(8'hC3, 16'h0002);
    repeat (200) @(negedge mclk);
    w = 16'h0000;
    while (lv === 1'b1 && w < 16'h012C) begin
      @(negedge mclk);
      w++;
    end
    w = 16'h0000;
    seen = 4'h0;
    repeat (2000) begin
      @(negedge mclk);
      if (lv === 1'b1) begin
        w++;
      end else if (w != 0) begin
        seen[0] = seen[0] | (w == 16'h000A);
        seen[1] = seen[1] | (w == 16'h0007);
        seen[2] = seen[2] | (w == 16'h000C);
        seen[3] = seen[3] | (w != 16'h000A && w != 16'h0007 && w != 16'h000C);
        w = 16'h0000;
      end
    end
    chk("pulse widths", 16'h0007, {12'h000, seen});
    wr(8'hC3, 16'h0000);
    // snapshot: nothing until triggered
    wr(8'h07, 16'h0108);
    repeat (3000) @(negedge mclk);
    chk("idle frame", 16'h0000, {15'h0000, fv});
    go = 1'b1;
    meas(1);
    go = 1'b0;
    chk("snapshot lines", 16'h0008, lines);
    // slave: host strobes drive exposure and every row
    wr(8'h07, 16'h0018);
    slave = 1'b1;
    repeat (3000) @(negedge mclk);
    chk("idle frame", 16'h0000, {15'h0000, fv});
    go = 1'b1;
    meas(1);
    go = 1'b0;
    chk("slave lines", 16'h0008, lines);
    chk("slave line clocks", 16'h0100, lvw);
    report_and_stop;
  end
endmodule // sts_timing_top_tb_top
